// ### bench/serial_peer.sv
`timescale 1ns/100ps
module serial_peer (
    // Clock and oversampling tick, sixteen per bit
    input wire logic clk_i,
    input wire logic tick_i,
    // Lines into the receiver
    output logic sin_o,
    output logic sir_o
);
    // Lines idle high between frames
    initial begin
        sin_o = 1'b1;
        sir_o = 1'b1;
    end
    // One bit time on the selected line
    task automatic bit_out(input logic v, input logic ir);
        @(posedge clk_i);
        if (ir) sir_o <= v;
        else sin_o <= v;
        repeat (16) @(posedge clk_i iff tick_i);
    endtask : bit_out
    // Kind: 0 good, 1 bad parity, 2 bad stop, 3 break
    task automatic send(input logic [7:0] d, input int nb, input logic parity_enable, input logic pev, input int kind,
                        input logic ir);
        logic p;
        p = (^(d & ~(8'hff << nb))) ^ !pev ^ (kind == 1);
        if (kind == 3) begin
            repeat (12) bit_out(1'b0, ir);
        end else begin
            bit_out(1'b0, ir);
            for (int i = 0; i < nb; i++) bit_out(d[i], ir);
            if (parity_enable) bit_out(p, ir);
            bit_out(kind != 2, ir);
        end
        bit_out(1'b1, ir);
    endtask : send
endmodule : serial_peer

// ### bench/uart_line_status_chk.sv
`timescale 1ns/100ps
module uart_line_status_chk (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // Bus side
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Transmit interrupt
    input wire logic tx_irq_o
);
    import uart_ls_pkg::*;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);
    // Config mirror, so mode-dependent flags can be judged
    logic [CFG_W-1:0] cfg_q;
    wire logic done = psel_i && penable_i && pready_o;
    wire logic st_rd = done && !pwrite_i && paddr_i == STATUS_ADDR;
    wire logic lvl_on = cfg_q[CFG_FIFO_EN] && cfg_q[CFG_LVL_MODE];
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            cfg_q <= CFG_RESET;
        end else if (done && pwrite_i && paddr_i == CFG_ADDR) begin
            cfg_q <= pwdata_i[CFG_W-1:0];
        end
    end
    // Bus handshake shape
    chk_ready_delay: assert property ((psel_i && !penable_i) |-> ##2 pready_o)
        else $error("ready late");
    chk_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready too long");
    chk_unmapped_err: assert property (done && paddr_i != DATA_ADDR && paddr_i != CFG_ADDR
        && paddr_i != STATUS_ADDR |-> pslverr_o && prdata_o == '0) else $error("unmapped not refused");
    chk_reserved_zero: assert property (st_rd |-> prdata_o[31:8] == '0 && !pslverr_o)
        else $error("status upper bits set");
    // Flag relations seen in a returned status word
    chk_break_flags: assert property (st_rd && prdata_o[BI_BIT] |-> prdata_o[FE_BIT] && prdata_o[PE_BIT])
        else $error("break without fe pe");
    chk_rfe_fifo_only: assert property (st_rd && !cfg_q[CFG_FIFO_EN] |-> !prdata_o[RFE_BIT])
        else $error("fifo error without fifo");
    chk_empty_order: assert property (st_rd && !lvl_on && prdata_o[TEMT_BIT] |-> prdata_o[THRE_BIT])
        else $error("empty without holding empty");
    chk_full_no_irq: assert property (st_rd && lvl_on && prdata_o[THRE_BIT] |-> !prdata_o[TEMT_BIT] ##1 !tx_irq_o)
        else $error("full flag wrong");
    chk_irq_follows: assert property (st_rd && cfg_q[CFG_TX_IRQ_EN] && !lvl_on && prdata_o[THRE_BIT]
        |-> ##[0:2] tx_irq_o) else $error("tx irq missing");
endmodule : uart_line_status_chk

bind uart_line_status uart_line_status_chk u_chk (.clk_sys_i, .nrst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .tx_irq_o);

// ### bench/uart_line_status_tb_top.sv
`timescale 1ns/100ps
module uart_line_status_tb_top;
    import uart_ls_pkg::*;
    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    logic tick = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [31:0] paddr_i = '0;
    logic [31:0] pwdata_i = '0;
    logic ce = 1'b1;
    logic sin_i, sir_in_i, tx_irq_o, pready_o, pslverr_o, err, sout;
    logic [31:0] prdata_o, rd;
    int n_mismatch = 0;
    int compares = 0;
    // Row: config, byte, frame kind, status seen, data seen
    typedef struct {logic [9:0] cfg; logic [7:0] d; int kind; logic [7:0] st; logic [7:0] dat;} row_s;
    row_s rows [7] = '{'{10'h300, 8'ha5, 0, 8'h61, 8'ha5}, '{10'h304, 8'h3c, 1, 8'h65, 8'h3c},
        '{10'h30c, 8'h3c, 0, 8'h61, 8'h3c}, '{10'h300, 8'h5a, 2, 8'h6b, 8'hff},
        '{10'h300, 8'h00, 3, 8'h7d, 8'h00}, '{10'h310, 8'h00, 3, 8'h7d, 8'h00}, '{10'h000, 8'h15, 0, 8'h61, 8'h15}};
    // Clock, and a tick every second cycle
    always #2 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) tick <= ~tick;
    uart_line_status u_dut (.clk_sys_i, .nrst_i, .ce_i(ce), .baud16_tick_i(tick), .sin_i, .sir_in_i, .sout_o(sout),
        .tx_irq_o, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o);
    serial_peer u_peer (.clk_i(clk_sys_i), .tick_i(tick), .sin_o(sin_i), .sir_o(sir_in_i));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One bus transfer; request held until ready is sampled
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        for (int n = 0; n < 20; n++) begin
            @(posedge clk_sys_i);
            if (pready_o === 1'b1) break;
            if (n == 19) n_mismatch++;
        end
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    task automatic st(input logic [7:0] e);
        apb(1'b0, STATUS_ADDR, '0);
        chk(rd, {24'h0, e});
    endtask : st
    task automatic tally_and_finish();
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    // Watchdog, well beyond the expected run
    initial begin
        #300000;
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        repeat (8) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        st(STATUS_RESET);
        apb(1'b1, STATUS_ADDR, 32'hff);
        st(STATUS_RESET);
        apb(1'b0, 32'h5000_1108, '0);
        chk({rd[30:0], err}, 32'h1);
        // Single-entry buffer, one row per frame
        foreach (rows[i]) begin
            apb(1'b1, CFG_ADDR, {22'h0, rows[i].cfg});
            u_peer.send(rows[i].d, 5 + rows[i].cfg[9:8], rows[i].cfg[2], rows[i].cfg[3], rows[i].kind, rows[i].cfg[4]);
            repeat (400) @(posedge clk_sys_i);
            st(rows[i].st);
            apb(1'b0, DATA_ADDR, '0);
            chk(rd, {24'h0, rows[i].dat});
            st(8'h60);
        end
        // FIFO: errored entry behind a good head
        apb(1'b1, CFG_ADDR, 32'h305);
        u_peer.send(8'h11, 8, 1'b1, 1'b0, 0, 1'b0);
        u_peer.send(8'h22, 8, 1'b1, 1'b0, 1, 1'b0);
        repeat (40) @(posedge clk_sys_i);
        st(8'he1);
        apb(1'b0, DATA_ADDR, '0);
        chk(rd, 32'h11);
        st(8'he5);
        st(8'h61);
        apb(1'b0, DATA_ADDR, '0);
        st(8'h60);
        // FIFO overrun: seventeenth char is lost
        apb(1'b1, CFG_ADDR, 32'h301);
        for (int i = 0; i < 17; i++) u_peer.send(i[7:0], 8, 1'b0, 1'b0, 0, 1'b0);
        repeat (40) @(posedge clk_sys_i);
        st(8'h63);
        for (int i = 0; i < 16; i++) begin
            apb(1'b0, DATA_ADDR, '0);
            chk(rd, i);
        end
        st(8'h60);
        // Transmit: holding-empty, shifter busy, interrupt
        apb(1'b1, CFG_ADDR, 32'h320);
        apb(1'b1, DATA_ADDR, 32'h96);
        st(8'h20);
        chk(tx_irq_o, 1'b1);
        chk(sout, 1'b0);
        apb(1'b1, DATA_ADDR, 32'h97);
        st(8'h00);
        chk(tx_irq_o, 1'b0);
        // Enable low must hold the shifter mid-frame
        ce <= 1'b0;
        repeat (800) @(posedge clk_sys_i);
        ce <= 1'b1;
        st(8'h00);
        repeat (800) @(posedge clk_sys_i);
        st(8'h60);
        // Threshold mode: flag means full, irq follows level
        apb(1'b1, CFG_ADDR, 32'h3e3);
        st(8'h40);
        chk(tx_irq_o, 1'b1);
        for (int i = 0; i < 17; i++) apb(1'b1, DATA_ADDR, i);
        st(8'h20);
        chk(tx_irq_o, 1'b0);
        apb(1'b1, CFG_ADDR, 32'h300);
        // Reset while a frame is going out
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        st(STATUS_RESET);
        chk(sout, 1'b1);
        tally_and_finish();
    end
endmodule : uart_line_status_tb_top

// ### core/uart_line_status.sv
`timescale 1ns/100ps
// Notes on behaviour
// RQ1 - With FIFOs on, FIFO error flag set while any stored char has error.
// RQ2 - FIFO error clears on status read only if no errored char remains behind head.
// RQ3 - Transmitter empty when shifter and FIFO/holding both empty; resets to one.
// RQ4 - Holding-empty set when transmit store empties into shifter; resets to one.
// RQ5 - Holding-empty raises transmit interrupt when enabled and threshold mode off.
// RQ6 - Threshold mode with FIFOs: holding-empty means FIFO full, interrupt follows threshold.
// RQ7 - Break set when serial input low longer than one whole frame.
// RQ8 - In infrared mode, break set when input pulsed low for over a frame.
// RQ9 - Break yields exactly one zero character; FIFO mode shows flag at head.
// RQ10 - Non-FIFO break flag sets at once, held until status read clears it.
// RQ11 - Framing error on missing stop bit; FIFO mode shows it at head.
// RQ12 - After framing error, stop position is taken as next start bit.
// RQ13 - A break also sets the framing error flag.
// RQ14 - Parity error only with parity enabled; FIFO mode shows it at head.
// RQ15 - A break also sets the parity error flag.
// RQ16 - Non-FIFO overrun when char arrives unread; new char overwrites buffer.
// RQ17 - FIFO overrun when char completes into full FIFO; new char dropped.
// RQ18 - Status read clears overrun, parity and framing flags.
// RQ19 - Data ready while any received char is held; resets to zero.
// RQ20 - Data ready clears on buffer read, or when FIFO runs empty.
// RQ21 - Cleared flags return old value; same-cycle events survive the clear.
module uart_line_status (
    // Clock, reset and enable
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    // Oversampling tick, sixteen per bit
    input wire logic baud16_tick_i,
    // Serial lines and transmit interrupt
    input wire logic sin_i,
    input wire logic sir_in_i,
    output logic sout_o,
    output logic tx_irq_o,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o
);
    import uart_ls_pkg::*;

    function automatic logic [3:0] char_len(input logic [1:0] sel);
        char_len = 4'h5 + {2'b00, sel};
    endfunction : char_len

    function automatic logic par_bit(input logic [7:0] d, input logic even);
        par_bit = even ? ^d : ~^d;
    endfunction : par_bit

    function automatic logic [7:0] len_mask(input logic [3:0] len);
        len_mask = 8'hff >> (4'h8 - len);
    endfunction : len_mask

    // Configuration
    logic [CFG_W-1:0] cfg_q;
    logic fifo_en, lvl_active, par_en, ir_mode;
    logic [3:0] len;
    logic [7:0] frame_ticks;
    assign fifo_en = cfg_q[CFG_FIFO_EN];
    assign lvl_active = cfg_q[CFG_LVL_MODE] & fifo_en;
    assign par_en = cfg_q[CFG_PAR_EN];
    assign ir_mode = cfg_q[CFG_IR_MODE];
    assign len = char_len(cfg_q[CFG_LEN_LO+1:CFG_LEN_LO]);
    assign frame_ticks = {len + 4'h2 + {3'b000, par_en}, 4'h0};

    // Pin synchronisers
    logic [1:0] sin_sync_q, sir_sync_q;
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            sin_sync_q <= 2'b11;
            sir_sync_q <= 2'b11;
        end else if (ce_i) begin
            sin_sync_q <= {sin_sync_q[0], sin_i};
            sir_sync_q <= {sir_sync_q[0], sir_in_i};
        end
    end

    // Infrared pulses stretched to a full bit, so a pulse train reads as a low line
    logic [4:0] ir_hold_q;
    logic rx_line;
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            ir_hold_q <= 5'h00;
        end else if (ce_i) begin
            if (!sir_sync_q[1]) begin
                ir_hold_q <= IR_HOLD_TICKS;
            end else if (baud16_tick_i && ir_hold_q != 5'h00) begin
                ir_hold_q <= ir_hold_q - 5'h01;
            end
        end
    end
    assign rx_line = ir_mode ? (ir_hold_q == 5'h00) : sin_sync_q[1];

    // Break detector: low for more than one whole frame
    logic [7:0] brk_cnt_q;
    logic break_det;
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            brk_cnt_q <= 8'h00;
        end else if (ce_i) begin
            if (rx_line) begin
                brk_cnt_q <= 8'h00;
            end else if (baud16_tick_i && brk_cnt_q != 8'hff) begin
                brk_cnt_q <= brk_cnt_q + 8'h01;
            end
        end
    end
    assign break_det = baud16_tick_i & ~rx_line & (brk_cnt_q == frame_ticks); // see RQ7 see RQ8

    // APB decode; one wait state so read data comes from a flop
    logic pready_q, slverr_q, done, hit_data, hit_cfg, hit_status;
    logic rd_status, rd_data, wr_data, wr_cfg, flush;
    logic [31:0] prdata_q;
    logic [7:0] status;
    assign hit_data = paddr_i == DATA_ADDR;
    assign hit_cfg = paddr_i == CFG_ADDR;
    assign hit_status = paddr_i == STATUS_ADDR;
    assign done = psel_i & penable_i & pready_q;
    assign rd_status = done & ~pwrite_i & hit_status;
    assign rd_data = done & ~pwrite_i & hit_data;
    assign wr_data = done & pwrite_i & hit_data;
    assign wr_cfg = done & pwrite_i & hit_cfg;
    // Toggling FIFO mode empties both stores so stale entries never mix modes
    assign flush = wr_cfg & (pwdata_i[CFG_FIFO_EN] != fifo_en);

    // Receive store
    logic [ENT_W-1:0] rx_mem [FIFO_DEPTH];
    logic [PTR_W-1:0] rx_rd_q, rx_wr_q;
    logic [CNT_W-1:0] rx_cnt_q, rx_cnt_d, rx_err_q, rx_cap;
    logic rx_push_q, rx_full, rx_pop, rx_accept, rx_ovw, overrun, head_arrive_q;
    logic [ENT_W-1:0] rx_ent_q, rx_head;
    logic new_err, head_err;
    assign rx_cap = fifo_en ? FIFO_FULL_CNT : 5'h01;
    assign rx_full = rx_cnt_q >= rx_cap;
    assign rx_pop = rd_data & (rx_cnt_q != 5'h00);
    assign rx_accept = rx_push_q & (~rx_full | rx_pop);
    assign overrun = rx_push_q & rx_full & ~rx_pop; // see RQ16 see RQ17
    assign rx_ovw = overrun & ~fifo_en; // see RQ16
    assign rx_head = rx_mem[rx_rd_q];
    assign new_err = |rx_ent_q[ENT_BI:ENT_PE];
    assign head_err = |rx_head[ENT_BI:ENT_PE];
    assign rx_cnt_d = rx_cnt_q + {4'h0, rx_accept} - {4'h0, rx_pop};

    // Receive entries; a full FIFO drops the new char, non-FIFO overwrites
    always_ff @(posedge clk_sys_i) begin
        if (ce_i && rx_accept) begin
            rx_mem[rx_wr_q] <= rx_ent_q;
        end else if (ce_i && rx_ovw) begin
            rx_mem[rx_rd_q] <= rx_ent_q;
        end
    end

    // Receive pointers, count and errored-entry count
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            rx_rd_q <= '0;
            rx_wr_q <= '0;
            rx_cnt_q <= '0;
            rx_err_q <= '0;
            head_arrive_q <= 1'b0;
        end else if (ce_i) begin
            if (flush) begin
                rx_rd_q <= '0;
                rx_wr_q <= '0;
                rx_cnt_q <= '0;
                rx_err_q <= '0;
                head_arrive_q <= 1'b0;
            end else begin
                rx_wr_q <= rx_wr_q + PTR_W'(rx_accept);
                rx_rd_q <= rx_rd_q + PTR_W'(rx_pop);
                rx_cnt_q <= rx_cnt_d; // see RQ20
                rx_err_q <= rx_err_q + {4'h0, rx_accept & new_err} - {4'h0, rx_pop & head_err};
                // A new char reaches the head when the store was empty or was popped
                head_arrive_q <= fifo_en & (rx_cnt_d != 5'h00) & ((rx_cnt_q == 5'h00) | rx_pop);
            end
        end
    end

    // Receiver state machine
    rx_state_e rx_state_q;
    logic [3:0] rx_tick_q, rx_bit_q;
    logic [7:0] rx_sh_q, rx_char;
    logic rx_par_q, rx_pe;
    assign rx_char = rx_sh_q >> (4'h8 - len);
    assign rx_pe = par_en & (rx_par_q != par_bit(rx_char, cfg_q[CFG_PAR_EVEN])); // see RQ14
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            rx_state_q <= RX_IDLE;
            rx_tick_q <= 4'h0;
            rx_bit_q <= 4'h0;
            rx_sh_q <= 8'h00;
            rx_par_q <= 1'b0;
            rx_push_q <= 1'b0;
            rx_ent_q <= '0;
        end else if (ce_i) begin
            rx_push_q <= 1'b0;
            if (baud16_tick_i) begin
                rx_tick_q <= rx_tick_q + 4'h1;
                case (rx_state_q)
                    RX_IDLE: begin
                        rx_tick_q <= 4'h0;
                        if (!rx_line) begin
                            rx_state_q <= RX_START;
                        end
                    end
                    RX_START: begin
                        if (rx_tick_q == MID_TICK) begin
                            rx_tick_q <= 4'h0;
                            rx_bit_q <= 4'h0;
                            rx_state_q <= rx_line ? RX_IDLE : RX_DATA;
                        end
                    end
                    RX_DATA: begin
                        if (rx_tick_q == LAST_TICK) begin
                            rx_sh_q <= {rx_line, rx_sh_q[7:1]};
                            rx_bit_q <= rx_bit_q + 4'h1;
                            if (rx_bit_q == len - 4'h1) begin
                                rx_state_q <= par_en ? RX_PAR : RX_STOP;
                            end
                        end
                    end
                    RX_PAR: begin
                        if (rx_tick_q == LAST_TICK) begin
                            rx_par_q <= rx_line;
                            rx_state_q <= RX_STOP;
                        end
                    end
                    RX_STOP: begin
                        if (rx_tick_q == LAST_TICK) begin
                            if (rx_line) begin
                                rx_push_q <= 1'b1;
                                rx_ent_q <= {2'b00, rx_pe, rx_char};
                                rx_state_q <= RX_IDLE;
                            end else if (rx_char == 8'h00 && !(par_en && rx_par_q)) begin
                                // All bits low so far: wait to tell break from framing error
                                rx_state_q <= RX_BRK;
                            end else begin
                                rx_push_q <= 1'b1;
                                rx_ent_q <= {2'b01, rx_pe, rx_char}; // see RQ11
                                rx_bit_q <= 4'h0;
                                rx_state_q <= RX_DATA; // see RQ12
                            end
                        end
                    end
                    RX_BRK: begin
                        if (break_det) begin
                            rx_push_q <= 1'b1;
                            rx_ent_q <= {3'b111, 8'h00}; // see RQ9 see RQ13 see RQ15
                            rx_state_q <= RX_WAIT_HIGH;
                        end else if (rx_line) begin
                            rx_push_q <= 1'b1;
                            rx_ent_q <= {2'b01, rx_pe, 8'h00}; // see RQ11
                            rx_state_q <= RX_IDLE;
                        end
                    end
                    RX_WAIT_HIGH: begin
                        // No further chars while the break lasts
                        if (rx_line) begin
                            rx_state_q <= RX_IDLE; // see RQ9
                        end
                    end
                    default: begin
                        rx_state_q <= RX_IDLE;
                    end
                endcase
            end
        end
    end

    // Sticky error flags; clear only the bits the read returned
    logic oe_q, pe_q, fe_q, bi_q, rfe_q, clr_ok, rfe_clr;
    logic [ENT_W-1:0] err_src;
    logic err_vld;
    assign err_vld = fifo_en ? head_arrive_q : rx_push_q; // see RQ9 see RQ10 see RQ11 see RQ14
    assign err_src = fifo_en ? rx_head : rx_ent_q;
    assign clr_ok = rx_err_q == 5'h00 || (rx_err_q == 5'h01 && head_err && rx_cnt_q != 5'h00);
    assign rfe_clr = rd_status & prdata_q[RFE_BIT] & clr_ok; // see RQ2
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            oe_q <= STATUS_RESET[OE_BIT];
            pe_q <= STATUS_RESET[PE_BIT];
            fe_q <= STATUS_RESET[FE_BIT];
            bi_q <= STATUS_RESET[BI_BIT];
            rfe_q <= STATUS_RESET[RFE_BIT];
        end else if (ce_i) begin
            // Set wins over a clear in the same cycle
            oe_q <= overrun | (oe_q & ~(rd_status & prdata_q[OE_BIT])); // see RQ18 see RQ21
            pe_q <= (err_vld & err_src[ENT_PE]) | (pe_q & ~(rd_status & prdata_q[PE_BIT])); // see RQ18
            fe_q <= (err_vld & err_src[ENT_FE]) | (fe_q & ~(rd_status & prdata_q[FE_BIT])); // see RQ18
            bi_q <= (err_vld & err_src[ENT_BI]) | (bi_q & ~(rd_status & prdata_q[BI_BIT])); // see RQ10
            rfe_q <= fifo_en & ~flush & ((rx_accept & new_err) | (rfe_q & ~rfe_clr)); // see RQ1 see RQ21
        end
    end

    // Transmit store
    logic [7:0] tx_mem [FIFO_DEPTH];
    logic [PTR_W-1:0] tx_rd_q, tx_wr_q;
    logic [CNT_W-1:0] tx_cnt_q;
    logic tx_push, tx_load, tx_busy_q, tx_full;
    logic [11:0] tx_sh_q, tx_frame;
    logic [3:0] tx_bits_q, tx_tick_q;
    logic [7:0] tx_d;
    assign tx_full = tx_cnt_q >= rx_cap;
    assign tx_push = wr_data & ~tx_full;
    assign tx_load = ~tx_busy_q & (tx_cnt_q != 5'h00) & ~flush;
    assign tx_d = tx_mem[tx_rd_q] & len_mask(len);

    // Frame: start, data LSB first, optional parity, stop, idle ones
    always_comb begin
        tx_frame = 12'hfff;
        tx_frame[0] = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (i < int'(len)) begin
                tx_frame[1+i] = tx_d[i];
            end
        end
        if (par_en) begin
            tx_frame[1+int'(len)] = par_bit(tx_d, cfg_q[CFG_PAR_EVEN]);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (ce_i && tx_push) begin
            tx_mem[tx_wr_q] <= pwdata_i[7:0];
        end
    end

    // Transmit pointers and shifter
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            tx_rd_q <= '0;
            tx_wr_q <= '0;
            tx_cnt_q <= '0;
            tx_busy_q <= 1'b0;
            tx_sh_q <= 12'hfff;
            tx_bits_q <= 4'h0;
            tx_tick_q <= 4'h0;
        end else if (ce_i) begin
            if (flush) begin
                tx_rd_q <= '0;
                tx_wr_q <= '0;
                tx_cnt_q <= '0;
            end else begin
                tx_wr_q <= tx_wr_q + PTR_W'(tx_push);
                tx_rd_q <= tx_rd_q + PTR_W'(tx_load);
                tx_cnt_q <= tx_cnt_q + {4'h0, tx_push} - {4'h0, tx_load};
            end
            if (tx_load) begin
                tx_busy_q <= 1'b1;
                tx_sh_q <= tx_frame;
                tx_bits_q <= len + 4'h2 + {3'b000, par_en};
                tx_tick_q <= 4'h0;
            end else if (tx_busy_q && baud16_tick_i) begin
                tx_tick_q <= tx_tick_q + 4'h1;
                if (tx_tick_q == LAST_TICK) begin
                    tx_sh_q <= {1'b1, tx_sh_q[11:1]};
                    tx_bits_q <= tx_bits_q - 4'h1;
                    tx_busy_q <= tx_bits_q != 4'h1;
                end
            end
        end
    end

    // Status word and transmit interrupt
    logic thre, temt, tx_irq_q;
    logic [CNT_W-1:0] thresh_lvl;
    assign thre = lvl_active ? tx_full : (tx_cnt_q == 5'h00); // see RQ4 see RQ6
    assign temt = ~tx_busy_q & (tx_cnt_q == 5'h00); // see RQ3
    always_comb begin
        case (cfg_q[CFG_THRESH_LO+1:CFG_THRESH_LO])
            2'h0: thresh_lvl = 5'h00;
            2'h1: thresh_lvl = 5'h02;
            2'h2: thresh_lvl = FIFO_FULL_CNT >> 2;
            default: thresh_lvl = FIFO_FULL_CNT >> 1;
        endcase
        status = 8'h00;
        status[DR_BIT] = rx_cnt_q != 5'h00; // see RQ19
        status[OE_BIT] = oe_q;
        status[PE_BIT] = pe_q;
        status[FE_BIT] = fe_q;
        status[BI_BIT] = bi_q;
        status[THRE_BIT] = thre;
        status[TEMT_BIT] = temt;
        status[RFE_BIT] = rfe_q;
    end

    // Interrupt is a level; threshold mode hands it to the FIFO level
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            tx_irq_q <= 1'b0;
        end else if (ce_i) begin
            tx_irq_q <= cfg_q[CFG_TX_IRQ_EN] & (lvl_active ? (tx_cnt_q <= thresh_lvl) : thre); // see RQ5 see RQ6
        end
    end

    // Configuration register and APB answer
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            cfg_q <= CFG_RESET;
            pready_q <= 1'b0;
            slverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else if (ce_i) begin
            if (wr_cfg) begin
                cfg_q <= pwdata_i[CFG_W-1:0];
            end
            pready_q <= psel_i & penable_i & ~pready_q;
            if (psel_i && penable_i && !pready_q) begin
                slverr_q <= ~(hit_data | hit_cfg | hit_status);
                if (pwrite_i) begin
                    prdata_q <= 32'h0000_0000;
                end else if (hit_status) begin
                    prdata_q <= {24'h00_0000, status}; // see RQ21
                end else if (hit_data) begin
                    prdata_q <= {24'h00_0000, rx_head[7:0]};
                end else if (hit_cfg) begin
                    prdata_q <= {22'h00_0000, cfg_q};
                end else begin
                    prdata_q <= 32'h0000_0000;
                end
            end
        end
    end

    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pready_q & slverr_q;
    assign sout_o = tx_sh_q[0];
    assign tx_irq_o = tx_irq_q;
endmodule : uart_line_status

// ### core/uart_ls_pkg.sv
package uart_ls_pkg;
    // Register byte addresses
    localparam logic [31:0] DATA_ADDR = 32'h5000_1100;
    localparam logic [31:0] CFG_ADDR = 32'h5000_1104;
    localparam logic [31:0] STATUS_ADDR = 32'h5000_1114;

    // Status word bit positions and reset value
    localparam int DR_BIT = 0;
    localparam int OE_BIT = 1;
    localparam int PE_BIT = 2;
    localparam int FE_BIT = 3;
    localparam int BI_BIT = 4;
    localparam int THRE_BIT = 5;
    localparam int TEMT_BIT = 6;
    localparam int RFE_BIT = 7;
    localparam logic [7:0] STATUS_RESET = 8'h60;

    // Configuration word fields
    localparam int CFG_FIFO_EN = 0;
    localparam int CFG_LVL_MODE = 1;
    localparam int CFG_PAR_EN = 2;
    localparam int CFG_PAR_EVEN = 3;
    localparam int CFG_IR_MODE = 4;
    localparam int CFG_TX_IRQ_EN = 5;
    localparam int CFG_THRESH_LO = 6;
    localparam int CFG_LEN_LO = 8;
    localparam int CFG_W = 10;
    localparam logic [CFG_W-1:0] CFG_RESET = 10'h000;

    // Receive entry layout: data in [7:0], then error marks
    localparam int ENT_PE = 8;
    localparam int ENT_FE = 9;
    localparam int ENT_BI = 10;
    localparam int ENT_W = 11;

    // Storage and timing
    localparam int FIFO_DEPTH = 16;
    localparam int PTR_W = 4;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] FIFO_FULL_CNT = 5'h10;
    localparam logic [3:0] MID_TICK = 4'h7;
    localparam logic [3:0] LAST_TICK = 4'hf;
    localparam logic [4:0] IR_HOLD_TICKS = 5'h10;

    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRK, RX_WAIT_HIGH} rx_state_e;
endpackage : uart_ls_pkg
